// file: rtl/pmw_consts.svh
// Constants of the motion wake-up unit: timing, limits, offsets and status bits
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH
`define PMW_CLK_NS       10
`define PMW_CLR_NS       35000
`define PMW_BLIND_NS     500000000
`define PMW_WIN_NS       2000000000
`define PMW_SMPL_NS      2000000
`define PMW_CFG_SMP_NS   36000
`define PMW_CFG_LOAD_NS  580000
`define PMW_ADC_LO       14'h01ff
`define PMW_ADC_HI       14'h3e01
`define PMW_BP_MAX       16'sh1fff
`define PMW_BP_MIN       -16'sh2000
`define PMW_CFG_BITS     5'h19
`define PMW_LPF_SH       2
`define PMW_HPF_SH_FAST  6
`define PMW_HPF_SH_SLOW  7
`define PMW_OFF_STATUS   8'h00
`define PMW_OFF_MASK     8'h04
`define PMW_OFF_CONFIG   8'h08
`define PMW_OFF_FRAME    8'h0c
`define PMW_OFF_STATE    8'h10
`define PMW_ST_ALARM     0
`define PMW_ST_OOR       1
`define PMW_ST_CFG       2
`define PMW_ST_SMPL      3
`define PMW_EVT_W        4
`define PMW_RESP_OKAY    2'h0
`define PMW_RESP_SLVERR  2'h2
`endif

// file: rtl/pmw_pkg.sv
// Types of the motion wake-up unit: modes, states, configuration and sample carrier
package pmw_pkg;
	typedef enum logic [1:0] {
		PMW_MODE_FORCED = 2'h0,
		PMW_MODE_IRQ_RD = 2'h1,
		PMW_MODE_ALARM  = 2'h2,
		PMW_MODE_RSVD   = 2'h3
	} pmw_mode_e;
	typedef enum logic [1:0] {
		PMW_SRC_BAND = 2'h0,
		PMW_SRC_LOW  = 2'h1,
		PMW_SRC_RSVD = 2'h2,
		PMW_SRC_TEMP = 2'h3
	} pmw_src_e;
	// Gray path: evaluate -> alarm -> blind; blind -> evaluate flips both bits
	typedef enum logic [1:0] {
		PMW_ST_EVAL  = 2'h0,
		PMW_ST_ALARM = 2'h1,
		PMW_ST_BLIND = 2'h3
	} pmw_state_e;
	typedef struct packed {
		logic [7:0] threshold;
		logic [3:0] blind;
		logic [1:0] pulses;
		logic [1:0] window;
		pmw_mode_e  mode;
		pmw_src_e   source;
		logic [1:0] rsvd_hi;
		logic       hpf_low;
		logic       rsvd_lo;
		logic       no_sign;
	} pmw_cfg_s;
	typedef struct packed {
		logic        valid;
		logic [13:0] data;
	} pmw_adc_s;
endpackage : pmw_pkg

// file: rtl/pmw_top.sv
// Motion wake-up unit: sampling, filters, pulse counting, alarm line, serial config, AXI4-Lite
// Behaviour
// R1 - Motion is judged only on band-pass filtered pyro samples.
// R2 - Motion unit runs only in alarm mode; host must pick that mode.
// R3 - Line is driven high once motion criteria are met in alarm mode.
// R4 - Alarm line stays high until the host clears it.
// R5 - Host clears an alarm by holding the line low at least 35 us.
// R6 - After clearing, motion detection pauses for the programmed blind period.
// R7 - Configuration is volatile and meaningless until the host loads one.
// R8 - Configuration is written only through the serial configuration input.
// R9 - Line serves as motion interrupt or as sample-ready stream signal.
// R10 - 14-bit converter input multiplexed between pyro elements and temperature sensor.
// R11 - Converter samples count only between 511 and 2^14 minus 511.
// R12 - A new sample every 2.0 to 12.5 ms.
// R13 - Low-pass and high-pass stages feed motion unit and data output.
// R14 - Mode field: 0 forced, 1 interrupt readout, 2 alarm, 3 reserved.
// R15 - Blind period is 0.5 s plus field times 0.5 s, from line fall.
// R16 - Pulse when band-pass magnitude exceeds threshold, either polarity.
// R17 - Alarm when 1 to 4 pulses fall within a 2 to 8 s window.
// R18 - All timing comes from counters on the own clock.
// R19 - While the alarm waits for clearance further motion is ignored.
`include "pmw_consts.svh"
module pmw_top #(
	parameter logic [31:0] SMPL_CYC   = (`PMW_SMPL_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS,
	parameter logic [31:0] BLIND_CYC  = `PMW_BLIND_NS / `PMW_CLK_NS,
	parameter logic [31:0] WIN_CYC    = `PMW_WIN_NS / `PMW_CLK_NS,
	parameter logic [31:0] LOAD_CYC   = (`PMW_CFG_LOAD_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS,
	parameter logic [31:0] CFG_SMP_CYC = (`PMW_CFG_SMP_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS
) (
	// Clock and reset
	input  wire logic              I_MCLK,
	input  wire logic              I_RESETN,
	// Converter
	input  wire pmw_pkg::pmw_adc_s I_ADC,
	output logic                   O_ADC_START,
	output logic                   O_ADC_MUX_TEMP,
	// Wake-up line and serial configuration input
	input  wire logic              I_DL_IN,
	output logic                   O_DL_OUT,
	output logic                   O_DL_OE,
	input  wire logic              I_CFG_SERIAL,
	// AXI4-Lite slave
	input  wire logic [7:0]        I_AWADDR,
	input  wire logic              I_AWVALID,
	output logic                   O_AWREADY,
	input  wire logic [31:0]       I_WDATA,
	input  wire logic [3:0]        I_WSTRB,
	input  wire logic              I_WVALID,
	output logic                   O_WREADY,
	output logic [1:0]             O_BRESP,
	output logic                   O_BVALID,
	input  wire logic              I_BREADY,
	input  wire logic [7:0]        I_ARADDR,
	input  wire logic              I_ARVALID,
	output logic                   O_ARREADY,
	output logic [31:0]            O_RDATA,
	output logic [1:0]             O_RRESP,
	output logic                   O_RVALID,
	input  wire logic              I_RREADY,
	// Interrupt
	output logic                   O_IRQ
);
	import pmw_pkg::*;

	localparam logic [11:0] CLR_CYC = 12'((`PMW_CLR_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS);

	pmw_cfg_s            cfg;
	logic                cfg_loaded;
	logic [24:0]         cfg_shift;
	logic [4:0]          cfg_bits;
	logic [31:0]         cfg_cnt;
	logic                cfg_armed;
	logic                cfg_prev;
	logic [31:0]         smp_cnt;
	logic                smp_temp;
	logic signed [15:0]  lp;
	logic signed [15:0]  base;
	logic                above_prev;
	logic                last_neg;
	logic [2:0]          pulse_cnt;
	logic [31:0]         win_cnt;
	pmw_state_e          state;
	logic [31:0]         blind_cnt;
	logic [11:0]         low_cnt;
	logic                rd_ready;
	logic [13:0]         frame_adc;
	logic                frame_ok;
	logic [3:0]          status;
	logic [3:0]          mask;
	logic                aw_got;
	logic                w_got;
	logic [7:0]          aw_addr;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;

	// Serial configuration receiver
	wire cfg_rise  = I_CFG_SERIAL && !cfg_prev;
	wire cfg_take  = cfg_armed && (cfg_cnt == CFG_SMP_CYC - 32'h1);
	wire cfg_idle  = (cfg_cnt == LOAD_CYC - 32'h1);
	wire load_now  = cfg_idle && (cfg_bits >= `PMW_CFG_BITS);

	// Each rising edge is a bit clock; the level is taken mid-way through its hold time
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			cfg_prev  <= 1'b0;
			cfg_cnt   <= 32'h0;
			cfg_armed <= 1'b0;
			cfg_shift <= 25'h0;
			cfg_bits  <= 5'h0;
		end else begin
			cfg_prev <= I_CFG_SERIAL;
			if (cfg_rise) begin
				cfg_cnt   <= 32'h0;
				cfg_armed <= 1'b1;
			end else if (!cfg_idle) begin
				cfg_cnt <= cfg_cnt + 32'h1;
			end
			if (cfg_take) begin
				cfg_shift <= {cfg_shift[23:0], I_CFG_SERIAL};
				cfg_armed <= 1'b0;
				if (cfg_bits != 5'h1f) begin
					cfg_bits <= cfg_bits + 5'h1;
				end
			end else if (cfg_idle) begin
				cfg_bits <= 5'h0;
			end
		end
	end

	// Configuration latch; alarm and readout modes stay off until a first word has landed
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			cfg        <= '0;
			cfg_loaded <= 1'b0;
		end else if (load_now) begin
			cfg        <= pmw_cfg_s'(cfg_shift); // R8 R7
			cfg_loaded <= 1'b1; // R7
		end
	end

	// Sample timer and converter mux
	wire smp_tick  = (smp_cnt == SMPL_CYC - 32'h1);
	wire in_range  = (I_ADC.data >= `PMW_ADC_LO) && (I_ADC.data <= `PMW_ADC_HI);
	wire pyro_ok   = I_ADC.valid && !smp_temp && in_range;
	wire oor_evt   = I_ADC.valid && !smp_temp && !in_range;
	assign O_ADC_START    = smp_tick; // R12
	assign O_ADC_MUX_TEMP = (cfg.source == PMW_SRC_TEMP); // R10

	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			smp_cnt  <= 32'h0;
			smp_temp <= 1'b0;
		end else begin
			smp_cnt <= smp_tick ? 32'h0 : smp_cnt + 32'h1; // R18
			if (smp_tick) begin
				smp_temp <= O_ADC_MUX_TEMP;
			end
		end
	end

	// Filters: first-order low-pass, slower baseline as high-pass; band is the difference
	wire signed [15:0] x_in     = {2'h0, I_ADC.data};
	wire signed [15:0] lp_step  = (x_in - lp) >>> `PMW_LPF_SH;
	wire signed [15:0] base_d   = lp - base;
	wire signed [15:0] base_stp = cfg.hpf_low ? (base_d >>> `PMW_HPF_SH_SLOW) : (base_d >>> `PMW_HPF_SH_FAST);
	wire signed [15:0] band_w   = base_d;
	wire signed [15:0] band_c   = (band_w > `PMW_BP_MAX) ? `PMW_BP_MAX :
	                              (band_w < `PMW_BP_MIN) ? `PMW_BP_MIN : band_w;
	wire [15:0]        band_mag = band_c[15] ? 16'(-band_c) : 16'(band_c);

	// Out-of-range samples leave the filter state untouched
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			lp   <= 16'sh0;
			base <= 16'sh0;
		end else if (pyro_ok) begin // R11
			lp   <= lp + lp_step; // R13
			base <= base + base_stp; // R13
		end
	end

	// Pulse detection on the band-pass value only
	wire evaluating = cfg_loaded && (cfg.mode == PMW_MODE_ALARM) && (state == PMW_ST_EVAL); // R2 R14 R19
	wire above      = band_mag > {8'h0, cfg.threshold}; // R16 R1
	wire sign_ok    = cfg.no_sign || (pulse_cnt == 3'h0) || (band_c[15] != last_neg);
	wire pulse_evt  = evaluating && pyro_ok && above && !above_prev && sign_ok; // R1
	wire win_end    = (pulse_cnt != 3'h0) && (win_cnt == 32'h0);
	wire hit        = pulse_evt && ({1'b0, cfg.pulses} == pulse_cnt[2:0]); // R17
	wire [31:0] win_total   = WIN_CYC * (32'(cfg.window) + 32'h1);
	wire [31:0] blind_total = BLIND_CYC * (32'(cfg.blind) + 32'h1);

	// Window opens at the first pulse and counts down; expiry drops the tally
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			above_prev <= 1'b0;
			last_neg   <= 1'b0;
			pulse_cnt  <= 3'h0;
			win_cnt    <= 32'h0;
		end else begin
			if (pyro_ok) begin
				above_prev <= above;
			end
			if (!evaluating || win_end || hit) begin
				pulse_cnt <= 3'h0; // R19
			end else if (pulse_evt) begin
				pulse_cnt <= pulse_cnt + 3'h1;
				last_neg  <= band_c[15];
				if (pulse_cnt == 3'h0) begin
					win_cnt <= win_total - 32'h1; // R17
				end
			end
			if (pulse_cnt != 3'h0 && win_cnt != 32'h0 && !(pulse_evt && pulse_cnt == 3'h0)) begin
				win_cnt <= win_cnt - 32'h1; // R18
			end
		end
	end

	// Host clearing: line low for the full clear time while we are signalling
	wire line_low  = !I_DL_IN && O_DL_OE;
	wire clr_seen  = line_low && (low_cnt == CLR_CYC - 12'h1); // R5
	wire smp_evt   = I_ADC.valid;
	wire rd_mode   = cfg_loaded && (cfg.mode == PMW_MODE_IRQ_RD); // R14

	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			low_cnt <= 12'h0;
		end else if (!line_low || clr_seen) begin
			low_cnt <= 12'h0;
		end else begin
			low_cnt <= low_cnt + 12'h1;
		end
	end

	// Alarm sequencer
	pmw_state_e next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			PMW_ST_EVAL:  if (hit) next_state = PMW_ST_ALARM; // R3
			PMW_ST_ALARM: if (clr_seen) next_state = PMW_ST_BLIND; // R4 R6
			PMW_ST_BLIND: if (blind_cnt == 32'h0) next_state = PMW_ST_EVAL; // R6
			default:      next_state = PMW_ST_EVAL;
		endcase
	end

	// Blind time is measured from the line's fall, so the clear time is taken off
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			state     <= PMW_ST_EVAL;
			blind_cnt <= 32'h0;
		end else begin
			state <= next_state;
			if (state == PMW_ST_ALARM && clr_seen) begin
				blind_cnt <= blind_total - 32'(CLR_CYC); // R15
			end else if (blind_cnt != 32'h0) begin
				blind_cnt <= blind_cnt - 32'h1;
			end
		end
	end

	// Readout-ready flag for interrupt readout mode; a new sample wins over a clear
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			rd_ready <= 1'b0;
		end else if (rd_mode && smp_evt) begin
			rd_ready <= 1'b1; // R9
		end else if (clr_seen || !rd_mode) begin
			rd_ready <= 1'b0;
		end
	end

	// Line drive: alarm in wake-up mode, sample-ready in readout mode
	assign O_DL_OUT = 1'b1;
	assign O_DL_OE  = (state == PMW_ST_ALARM) || rd_ready; // R3 R4 R9

	// Readout frame; the ok bit returns only once a frame read has completed
	logic frame_rd_q;
	wire  rd_frame = O_RVALID && I_RREADY && frame_rd_q; // R11
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			frame_adc <= 14'h0;
			frame_ok  <= 1'b1;
		end else begin
			if (smp_evt) begin
				unique case (cfg.source)
					PMW_SRC_BAND: frame_adc <= band_c[13:0]; // R13
					PMW_SRC_LOW:  frame_adc <= lp[13:0];
					default:      frame_adc <= I_ADC.data;
				endcase
			end
			if (oor_evt) begin
				frame_ok <= 1'b0; // R11
			end else if (rd_frame) begin
				frame_ok <= 1'b1;
			end
		end
	end

	// Status flags: events win over a same-cycle write-one-to-clear
	wire [3:0] evt = {smp_evt, load_now, oor_evt, hit};
	wire wr_fire   = aw_got && w_got && !O_BVALID;
	wire wr_status = wr_fire && (aw_addr == `PMW_OFF_STATUS) && w_strb[0];
	wire wr_mask   = wr_fire && (aw_addr == `PMW_OFF_MASK) && w_strb[0];
	wire wr_ok     = (aw_addr == `PMW_OFF_STATUS) || (aw_addr == `PMW_OFF_MASK);
	assign O_IRQ   = |(status & mask);

	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			status <= 4'h0;
			mask   <= 4'h0;
		end else begin
			status <= (status & ~(wr_status ? w_data[3:0] : 4'h0)) | evt;
			if (wr_mask) begin
				mask <= w_data[3:0];
			end
		end
	end

	// AXI4-Lite write: address and data taken in any order, response after both
	assign O_AWREADY = !aw_got;
	assign O_WREADY  = !w_got;
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			aw_got   <= 1'b0;
			w_got    <= 1'b0;
			aw_addr  <= 8'h0;
			w_data   <= 32'h0;
			w_strb   <= 4'h0;
			O_BVALID <= 1'b0;
			O_BRESP  <= `PMW_RESP_OKAY;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				aw_got  <= 1'b1;
				aw_addr <= I_AWADDR;
			end
			if (I_WVALID && O_WREADY) begin
				w_got  <= 1'b1;
				w_data <= I_WDATA;
				w_strb <= I_WSTRB;
			end
			if (wr_fire) begin
				O_BVALID <= 1'b1;
				O_BRESP  <= wr_ok ? `PMW_RESP_OKAY : `PMW_RESP_SLVERR; // R8
			end else if (O_BVALID && I_BREADY) begin
				O_BVALID <= 1'b0;
				aw_got   <= 1'b0;
				w_got    <= 1'b0;
			end
		end
	end

	// AXI4-Lite read decode
	wire [31:0] rd_mux =
		(I_ARADDR == `PMW_OFF_STATUS) ? {28'h0, status} :
		(I_ARADDR == `PMW_OFF_MASK)   ? {28'h0, mask} :
		(I_ARADDR == `PMW_OFF_CONFIG) ? {7'h0, 25'(cfg)} :
		(I_ARADDR == `PMW_OFF_FRAME)  ? {15'h0, frame_ok, 2'h0, frame_adc} :
		(I_ARADDR == `PMW_OFF_STATE)  ? {23'h0, cfg_loaded, 3'h0, pulse_cnt, 2'(state)} : 32'h0;
	wire rd_hit = (I_ARADDR == `PMW_OFF_STATUS) || (I_ARADDR == `PMW_OFF_MASK) ||
	              (I_ARADDR == `PMW_OFF_CONFIG) || (I_ARADDR == `PMW_OFF_FRAME) ||
	              (I_ARADDR == `PMW_OFF_STATE);
	assign O_ARREADY = !O_RVALID;
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			O_RVALID   <= 1'b0;
			O_RDATA    <= 32'h0;
			O_RRESP    <= `PMW_RESP_OKAY;
			frame_rd_q <= 1'b0;
		end else if (I_ARVALID && O_ARREADY) begin
			O_RVALID   <= 1'b1;
			O_RDATA    <= rd_mux;
			O_RRESP    <= rd_hit ? `PMW_RESP_OKAY : `PMW_RESP_SLVERR;
			frame_rd_q <= (I_ARADDR == `PMW_OFF_FRAME);
		end else if (O_RVALID && I_RREADY) begin
			O_RVALID <= 1'b0;
		end
	end

	// Checks on the alarm path, sampling and configuration
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RESETN);

	sequence s_alarm_hit;
		state == PMW_ST_EVAL && hit;
	endsequence
	sequence s_host_clear;
		state == PMW_ST_ALARM && clr_seen;
	endsequence

	AST_ALARM_RAISE: assert property (s_alarm_hit |=> O_DL_OE && O_DL_OUT && state == PMW_ST_ALARM) // R3
		else $error("alarm not raised after motion hit");
	AST_ALARM_HOLD: assert property (state == PMW_ST_ALARM && !clr_seen |=> state == PMW_ST_ALARM && O_DL_OE) // R4
		else $error("alarm line dropped without host clear");
	AST_MODE_GATE: assert property ($rose(state == PMW_ST_ALARM) |-> $past(cfg.mode) == PMW_MODE_ALARM) // R2
		else $error("alarm raised outside alarm mode");
	AST_CLEAR_TIME: assert property (s_host_clear |-> $past(low_cnt, 1) == CLR_CYC - 12'h2 && $past(line_low)) // R5
		else $error("clear accepted before full low time");
	AST_BLIND_ENTRY: assert property (s_host_clear |=> state == PMW_ST_BLIND ##1 blind_cnt < blind_total) // R6 R15
		else $error("blind period not started on clear");
	AST_BLIND_QUIET: assert property (state != PMW_ST_EVAL |-> !pulse_evt ##1 pulse_cnt == 3'h0) // R6 R19
		else $error("pulse counted while blind or alarmed");
	AST_BAND_ONLY: assert property (pulse_evt |-> !smp_temp && in_range && band_mag > {8'h0, cfg.threshold}) // R1 R16
		else $error("pulse from non band-pass data");
	AST_RANGE_SKIP: assert property (oor_evt |=> $stable(lp) && $stable(base) && !frame_ok) // R11
		else $error("out-of-range sample reached the filters");
	AST_SMPL_GAP: assert property (O_ADC_START |=> !O_ADC_START [*2]) // R12
		else $error("sample starts too close together");
	AST_CFG_SOURCE: assert property (!$stable(cfg) |-> $past(load_now)) // R8 R7
		else $error("configuration changed without serial load");
endmodule : pmw_top

// file: bench/pmw_host_model.sv
// Host-side partner of the motion wake-up unit: wake-up line pull-down and serial config
module pmw_host_model #(
	parameter int CFG_SMP_CYC = 20,
	parameter int LOAD_CYC    = 60
) (
	// Clock
	input  wire logic i_clk,
	// Device side of the wake-up line
	input  wire logic i_dl_out,
	input  wire logic i_dl_oe,
	// Resolved line and serial configuration
	output logic      o_line,
	output logic      o_cfg_serial
);
	// Levels start idle; only the tasks below change them
	logic pull_low = 1'b0;
	logic cfg_lvl  = 1'b0;

	assign o_cfg_serial = cfg_lvl;

	// Line has a pull-down, so nobody driving reads as low
	assign o_line = pull_low ? 1'b0 : (i_dl_oe ? i_dl_out : 1'b0);

	// Host grabs or lets go of the line just after an edge
	task automatic drive_low(input logic v);
		@(posedge i_clk);
		pull_low <= v;
	endtask : drive_low

	// MSB first; level held well past the sampling point so no bit is caught mid-change
	task automatic send_cfg(input logic [24:0] w);
		for (int b = 24; b >= 0; b--) begin
			repeat (2) @(posedge i_clk);
			cfg_lvl <= 1'b1;
			repeat (2) @(posedge i_clk);
			cfg_lvl <= w[b];
			repeat (CFG_SMP_CYC + 10) @(posedge i_clk);
			cfg_lvl <= 1'b0;
		end
		// Quiet gap longer than the load time latches the word
		repeat (LOAD_CYC + 20) @(posedge i_clk);
	endtask : send_cfg
endmodule : pmw_host_model

// file: bench/pmw_top_tb.sv
// Self-checking bench of the motion wake-up unit with host model and converter stub
`include "pmw_consts.svh"
module pmw_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pmw_pkg::*;
	localparam logic [1:0] OK = `PMW_RESP_OKAY;
	localparam logic [1:0] ER = `PMW_RESP_SLVERR;
	localparam logic [7:0] A_ST = `PMW_OFF_STATUS;
	localparam logic [7:0] A_MK = `PMW_OFF_MASK;
	localparam logic [7:0] A_CF = `PMW_OFF_CONFIG;
	localparam logic [7:0] A_SE = `PMW_OFF_STATE;
	localparam logic [7:0] A_FR = `PMW_OFF_FRAME;
	// Sample period shares no factor with the clear time, so a clear cannot keep landing on a sample
	localparam logic [31:0] SMPL = 32'd53;
	logic        clk, rst_n, adc_start, mux_temp, dl_out, dl_oe, line, cfg_ser, irq;
	pmw_adc_s    adc = '0;
	logic [3:0]  wstrb;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [13:0] adc_val;
	logic        spike_en;
	logic [2:0]  smp_n = 3'h0;
	int          err_total, n_tests, cyc;

	pmw_top #(.SMPL_CYC(SMPL), .BLIND_CYC(32'd1000), .WIN_CYC(32'd400), .LOAD_CYC(32'd60),
		.CFG_SMP_CYC(32'd20)) i_dut (
		.I_MCLK(clk), .I_RESETN(rst_n), .I_ADC(adc), .O_ADC_START(adc_start), .O_ADC_MUX_TEMP(mux_temp),
		.I_DL_IN(line), .O_DL_OUT(dl_out), .O_DL_OE(dl_oe), .I_CFG_SERIAL(cfg_ser),
		.I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
		.I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
		.I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
		.O_RVALID(rvalid), .I_RREADY(rready), .O_IRQ(irq));

	pmw_host_model i_host (.i_clk(clk), .i_dl_out(dl_out),
		.i_dl_oe(dl_oe), .o_line(line), .o_cfg_serial(cfg_ser));

	always #5 clk = ~clk;

	// Converter stub answers one cycle after each start; sparse spikes give clean pulses
	always @(posedge clk) begin
		adc.valid <= adc_start;
		if (adc_start) begin
			adc.data <= (spike_en && smp_n == 3'h0) ? 14'h2800 : adc_val;
			smp_n    <= smp_n + 3'h1;
		end
	end

	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk1

	// Write with address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				chk({30'h0, bresp}, {30'h0, er});
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				chk(rdata & m, e);
				chk({30'h0, rresp}, {30'h0, er});
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd

	// Bounded wait for the line enable to reach a level
	task automatic wait_oe(input logic v, input int lim, output int n);
		n = 0;
		while (dl_oe !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk1(dl_oe, v);
	endtask : wait_oe

	task automatic oe_count(input int len, output int c);
		c = 0;
		repeat (len) begin
			@(posedge clk);
			c += (dl_oe === 1'b1) ? 1 : 0;
		end
	endtask : oe_count

	function automatic pmw_cfg_s mk_cfg(input pmw_mode_e m, input pmw_src_e s);
		mk_cfg = '{threshold: 8'ha0, blind: 4'h4, pulses: 2'h0, window: 2'h0, mode: m, source: s,
			rsvd_hi: 2'h2, hpf_low: 1'b0, rsvd_lo: 1'b0, no_sign: 1'b1};
	endfunction : mk_cfg

	task automatic t_reset();
		chk1(dl_oe, 1'b0);
		chk1(irq, 1'b0);
		rd(A_SE, 32'h100, 32'h0, OK);
		rd(8'h20, 32'hffffffff, 32'h0, ER);
		wr(8'h24, 32'h1, ER);
		$display("test reset done");
	endtask : t_reset

	// Temperature source last would stall the pyro filters, so walk sources downwards
	task automatic t_source();
		pmw_cfg_s c;
		int       n;
		for (int i = 3; i >= 0; i--) begin
			c = mk_cfg(i[0] ? PMW_MODE_RSVD : PMW_MODE_FORCED, pmw_src_e'(i[1:0]));
			i_host.send_cfg(c);
			chk1(mux_temp, (i == 3));
			oe_count(300, n);
			chk(n, 0);
			rd(A_CF, 32'hffffffff, {7'h0, c}, OK);
		end
		wr(A_CF, 32'h0, ER);
		rd(A_CF, 32'hffffffff, {7'h0, c}, OK);
		while (adc_start !== 1'b1) @(posedge clk);
		@(posedge clk);
		n = 1;
		while (adc_start !== 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		chk(n, SMPL);
		$display("test source done");
	endtask : t_source

	task automatic t_alarm();
		int n;
		spike_en <= 1'b1;
		wr(A_MK, 32'h1, OK);
		rd(A_MK, 32'hf, 32'h1, OK);
		i_host.send_cfg(mk_cfg(PMW_MODE_ALARM, PMW_SRC_LOW));
		wait_oe(1'b1, 1000, n);
		rd(A_ST, 32'h1, 32'h1, OK);
		chk1(irq, 1'b1);
		oe_count(1000, n);
		chk(n, 1000);
		rd(A_SE, 32'h3, 32'h1, OK);
		wr(A_MK, 32'h0, OK);
		chk1(irq, 1'b0);
		wr(A_MK, 32'h1, OK);
		chk1(irq, 1'b1);
		// Lane 0 off: the write is answered but leaves the mask alone
		wstrb <= 4'he;
		wr(A_MK, 32'h0, OK);
		wstrb <= 4'hf;
		chk1(irq, 1'b1);
		wr(A_ST, 32'h1, OK);
		chk1(irq, 1'b0);
		$display("test alarm done");
	endtask : t_alarm

	// Short low pulse ignored; long one clears; blind of five steps counted from the fall
	task automatic t_clear();
		int n;
		i_host.drive_low(1'b1);
		repeat (3000) @(posedge clk);
		i_host.drive_low(1'b0);
		repeat (20) @(posedge clk);
		chk1(dl_oe, 1'b1);
		i_host.drive_low(1'b1);
		repeat (3400) @(posedge clk);
		chk1(dl_oe, 1'b1);
		wait_oe(1'b0, 200, n);
		chk1((n >= 100) && (n <= 110), 1'b1);
		rd(A_SE, 32'h3, 32'h3, OK);
		i_host.drive_low(1'b0);
		oe_count(1400, n);
		chk(n, 0);
		wait_oe(1'b1, 1000, n);
		$display("test clear done");
	endtask : t_clear

	task automatic t_range();
		spike_en <= 1'b0;
		wr(A_ST, 32'hf, OK);
		adc_val <= 14'h01ff;
		repeat (150) @(posedge clk);
		adc_val <= 14'h3e01;
		repeat (150) @(posedge clk);
		rd(A_ST, 32'h2, 32'h0, OK);
		adc_val <= 14'h01fe;
		repeat (150) @(posedge clk);
		rd(A_ST, 32'h2, 32'h2, OK);
		adc_val <= 14'h2000;
		repeat (150) @(posedge clk);
		rd(A_FR, 32'h10000, 32'h0, OK);
		rd(A_FR, 32'h10000, 32'h10000, OK);
		$display("test range done");
	endtask : t_range

	// Samples raise the line; a full host low drops it until the next sample
	task automatic t_readout();
		int n;
		i_host.send_cfg(mk_cfg(PMW_MODE_IRQ_RD, PMW_SRC_BAND));
		wait_oe(1'b1, 120, n);
		i_host.drive_low(1'b1);
		wait_oe(1'b0, 7200, n);
		chk1(n >= 3400, 1'b1);
		i_host.drive_low(1'b0);
		wait_oe(1'b1, 60, n);
		$display("test readout done");
	endtask : t_readout

	initial begin
		clk      = 1'b0;
		rst_n    = 1'b0;
		wstrb    = 4'hf;
		awaddr   = 8'h0;
		araddr   = 8'h0;
		wdata    = 32'h0;
		awvalid  = 1'b0;
		wvalid   = 1'b0;
		bready   = 1'b0;
		arvalid  = 1'b0;
		rready   = 1'b0;
		adc_val  = 14'h2000;
		spike_en = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_source();
		repeat (30000) @(posedge clk);
		t_alarm();
		t_clear();
		t_range();
		t_readout();
		conclude();
	end
endmodule : pmw_top_tb
